// [core/dmcs_sequencer.sv]
// disk macro command sequencer: command decode, stepping, buffer, host handshake
`timescale 1ns/1ps
module dmcs_sequencer
(
   // clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // task file and command from host
   input wire logic cmd_write,
   input wire logic [7:0] cmd_byte,
   input wire logic [7:0] sector_count,
   input wire logic [7:0] sector_number,
   input wire logic [9:0] target_cyl,
   input wire logic [9:0] precomp_cyl,
   input wire logic floppy_sel,
   // host data port
   input wire logic data_rd,
   input wire logic data_wr,
   input wire logic [7:0] data_in,
   output logic [7:0] data_out,
   output logic transfer_request,
   output logic host_interrupt,
   output logic busy,
   // task file readback
   output logic [7:0] sector_number_rb,
   output logic [7:0] sector_count_rb,
   // drive control and status
   output logic step,
   output logic direction_in,
   output logic write_gate,
   output logic precomp_en,
   input wire logic track0,
   input wire logic seek_complete,
   input wire logic drive_ready,
   input wire logic write_fault,
   // disk data path
   input wire logic id_found,
   input wire logic [7:0] disk_rd_data,
   input wire logic disk_rd_valid,
   output logic [7:0] disk_wr_data,
   input wire logic disk_wr_take,
   output logic format_active,
   output logic raw_ecc
);
   dmcs_pkg::dmcs_state_e state_r;
   logic [3:0] rate_r;
   logic [3:0] op_r;
   logic restore_r, flag_d_r, flag_m_r, flag_l_r;
   logic [9:0] cur_cyl_r, tgt_cyl_r;
   logic [7:0] sect_left_r, sect_num_r;
   logic [9:0] ptr_r, last_r;
   logic [7:0] buf_mem [0:dmcs_pkg::BUF_DEPTH-1];
   logic [7:0] data_out_r, wr_data_r;
   logic int_r, step_r, dir_r, gate_r, pcomp_r;
   logic tmr_start, tmr_done, at_target, drive_ok, is_rd, host_phase, disk_beat;
   logic [23:0] interval;
   logic [3:0] eff_rate;

   // ----------------------------------------------------------------
   // step interval selection
   // ----------------------------------------------------------------
   // floppy restore never faster than the fixed floppy interval
   always_comb
   begin
      eff_rate = rate_r;
      if (eff_rate == dmcs_pkg::RATE_RESET)
         interval = 24'(dmcs_pkg::ZERO_CYC);
      else
         interval = 24'(dmcs_pkg::UNIT_CYC * int'(eff_rate));
      if (restore_r && floppy_sel && interval < 24'(dmcs_pkg::FLOPPY_RATE_CYC))
         interval = 24'(dmcs_pkg::FLOPPY_RATE_CYC);
   end

   dmcs_step_timer u_timer
   (
      .mclk(mclk),
      .resetn(resetn),
      .start(tmr_start),
      .interval(interval),
      .expired(tmr_done)
   );

   assign is_rd = op_r == dmcs_pkg::CMD_READ;
   // only the stream of the current direction moves the pointer
   assign disk_beat = is_rd ? disk_rd_valid : disk_wr_take;
   assign at_target = restore_r ? track0 : (cur_cyl_r == tgt_cyl_r);
   // floppy: status lines and write fault not consulted
   assign drive_ok = floppy_sel || (drive_ready && seek_complete && !write_fault);
   assign tmr_start = state_r == dmcs_pkg::ST_STEP;
   assign host_phase = state_r == dmcs_pkg::ST_HOSTIN || state_r == dmcs_pkg::ST_HOSTOUT;

   // ----------------------------------------------------------------
   // command acceptance and stored rate
   // ----------------------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (!resetn)
      begin
         rate_r <= dmcs_pkg::RATE_RESET;
         op_r <= 4'h0;
         restore_r <= 1'b0;
         flag_d_r <= 1'b0;
         flag_m_r <= 1'b0;
         flag_l_r <= 1'b0;
         tgt_cyl_r <= 10'h000;
      end
      else if (cmd_write && state_r == dmcs_pkg::ST_IDLE)
      begin
         op_r <= cmd_byte[dmcs_pkg::CMD_OP_HI:dmcs_pkg::CMD_OP_LO];
         restore_r <= cmd_byte[dmcs_pkg::CMD_OP_HI:dmcs_pkg::CMD_OP_LO] == dmcs_pkg::CMD_RESTORE;
         tgt_cyl_r <= target_cyl;
         flag_d_r <= cmd_byte[dmcs_pkg::FLAG_D];
         flag_m_r <= cmd_byte[dmcs_pkg::FLAG_M];
         flag_l_r <= cmd_byte[dmcs_pkg::FLAG_L] && !floppy_sel;
         if (cmd_byte[dmcs_pkg::CMD_OP_HI:dmcs_pkg::CMD_OP_LO] == dmcs_pkg::CMD_RESTORE ||
             cmd_byte[dmcs_pkg::CMD_OP_HI:dmcs_pkg::CMD_OP_LO] == dmcs_pkg::CMD_SEEK)
            rate_r <= cmd_byte[dmcs_pkg::RATE_HI:dmcs_pkg::RATE_LO];
      end
   end

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (!resetn)
         state_r <= dmcs_pkg::ST_IDLE;
      else
      begin
         unique case (state_r)
            dmcs_pkg::ST_IDLE:
               if (cmd_write)
                  state_r <= dmcs_pkg::ST_CHECK;
            dmcs_pkg::ST_CHECK:
               if (!drive_ok)
                  state_r <= dmcs_pkg::ST_DONE;
               else if (op_r == dmcs_pkg::CMD_WRITE || op_r == dmcs_pkg::CMD_FORMAT)
                  state_r <= dmcs_pkg::ST_HOSTIN;
               else if (!at_target)
                  state_r <= dmcs_pkg::ST_STEP;
               else
                  state_r <= is_rd ? dmcs_pkg::ST_FIND : dmcs_pkg::ST_DONE;
            dmcs_pkg::ST_STEP:
               state_r <= dmcs_pkg::ST_WAIT;
            dmcs_pkg::ST_WAIT:
               // hard-disk restore handshakes on seek complete, else timed
               if ((restore_r && !floppy_sel) ? (seek_complete && !step_r) : tmr_done)
               begin
                  if (!at_target)
                     state_r <= dmcs_pkg::ST_STEP;
                  else if (op_r == dmcs_pkg::CMD_RESTORE || op_r == dmcs_pkg::CMD_SEEK)
                     state_r <= dmcs_pkg::ST_DONE;
                  else
                     state_r <= dmcs_pkg::ST_FIND;
               end
            dmcs_pkg::ST_HOSTIN:
               if (data_wr && ptr_r == last_r)
                  state_r <= at_target ? dmcs_pkg::ST_FIND : dmcs_pkg::ST_STEP;
            dmcs_pkg::ST_FIND:
               if (id_found || op_r == dmcs_pkg::CMD_FORMAT)
                  state_r <= dmcs_pkg::ST_DISK;
            dmcs_pkg::ST_DISK:
               if (disk_beat && ptr_r == last_r)
                  state_r <= is_rd ? dmcs_pkg::ST_HOSTOUT : dmcs_pkg::ST_NEXT;
            dmcs_pkg::ST_HOSTOUT:
               if (data_rd && ptr_r == last_r)
                  state_r <= dmcs_pkg::ST_NEXT;
            dmcs_pkg::ST_NEXT:
               if (flag_m_r && sect_left_r > 8'h01 && op_r != dmcs_pkg::CMD_FORMAT)
                  state_r <= is_rd ? dmcs_pkg::ST_FIND : dmcs_pkg::ST_HOSTIN;
               else
                  state_r <= dmcs_pkg::ST_DONE;
            dmcs_pkg::ST_DONE:
               state_r <= dmcs_pkg::ST_IDLE;
            default:
               state_r <= dmcs_pkg::ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // head position and step pulses
   // ----------------------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (!resetn)
      begin
         cur_cyl_r <= 10'h000;
         step_r <= 1'b0;
         dir_r <= 1'b0;
      end
      else if (state_r == dmcs_pkg::ST_STEP)
      begin
         step_r <= 1'b1;
         dir_r <= !restore_r && tgt_cyl_r > cur_cyl_r;
         if (restore_r)
            cur_cyl_r <= 10'h000;
         else if (tgt_cyl_r > cur_cyl_r)
            cur_cyl_r <= cur_cyl_r + 10'h001;
         else
            cur_cyl_r <= cur_cyl_r - 10'h001;
      end
      else
         step_r <= 1'b0;
   end

   // ----------------------------------------------------------------
   // sector counting
   // ----------------------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (!resetn)
      begin
         sect_left_r <= 8'h00;
         sect_num_r <= 8'h00;
      end
      else if (cmd_write && state_r == dmcs_pkg::ST_IDLE)
      begin
         sect_left_r <= sector_count;
         sect_num_r <= sector_number;
      end
      else if (state_r == dmcs_pkg::ST_NEXT && sect_left_r > 8'h01 && flag_m_r &&
               op_r != dmcs_pkg::CMD_FORMAT)
      begin
         sect_left_r <= sect_left_r - 8'h01;
         sect_num_r <= sect_num_r + 8'h01;
      end
   end

   // task registers show last value, updated to failing sector
   assign sector_number_rb = sect_num_r;
   assign sector_count_rb = sect_left_r;

   // ----------------------------------------------------------------
   // sector buffer
   // ----------------------------------------------------------------
   // format: two bytes per sector, bad-block flag then sector number
   always_comb
   begin
      if (op_r == dmcs_pkg::CMD_FORMAT)
         last_r = 10'(int'(sect_left_r) * dmcs_pkg::FMT_ENTRY_BYTES - 1);
      else if (flag_l_r)
         last_r = 10'(dmcs_pkg::BUF_DEPTH - 1);
      else
         last_r = 10'(dmcs_pkg::SECT_BYTES - 1);
   end

   always_ff @(posedge mclk)
   begin
      if (!resetn)
         ptr_r <= 10'h000;
      else if (state_r == dmcs_pkg::ST_CHECK || state_r == dmcs_pkg::ST_NEXT ||
               state_r == dmcs_pkg::ST_FIND)
         ptr_r <= 10'h000;
      else if ((state_r == dmcs_pkg::ST_HOSTIN && data_wr) ||
               (state_r == dmcs_pkg::ST_HOSTOUT && data_rd) ||
               (state_r == dmcs_pkg::ST_DISK && disk_beat))
         ptr_r <= (ptr_r == last_r) ? 10'h000 : ptr_r + 10'h001;
   end

   always_ff @(posedge mclk)
   begin
      if (state_r == dmcs_pkg::ST_HOSTIN && data_wr)
         buf_mem[ptr_r] <= data_in;
      else if (state_r == dmcs_pkg::ST_DISK && is_rd && disk_rd_valid)
         buf_mem[ptr_r] <= disk_rd_data;
   end

   always_ff @(posedge mclk)
   begin
      if (!resetn)
      begin
         data_out_r <= 8'h00;
         wr_data_r <= 8'h00;
      end
      else
      begin
         data_out_r <= buf_mem[ptr_r];
         wr_data_r <= buf_mem[ptr_r];
      end
   end

   // ----------------------------------------------------------------
   // write gate and precompensation
   // ----------------------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (!resetn)
      begin
         gate_r <= 1'b0;
         pcomp_r <= 1'b0;
      end
      else
      begin
         gate_r <= state_r == dmcs_pkg::ST_DISK && !is_rd;
         pcomp_r <= !floppy_sel && cur_cyl_r >= precomp_cyl;
      end
   end

   // ----------------------------------------------------------------
   // host interrupt
   // ----------------------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (!resetn)
         int_r <= 1'b0;
      else if (cmd_write && state_r == dmcs_pkg::ST_IDLE)
         int_r <= 1'b0;
      else if (is_rd && !flag_d_r && state_r == dmcs_pkg::ST_DISK &&
               disk_rd_valid && ptr_r == last_r)
         int_r <= 1'b1;
      else if (state_r == dmcs_pkg::ST_DONE)
         int_r <= 1'b1;
   end

   assign transfer_request = host_phase;
   assign busy = state_r != dmcs_pkg::ST_IDLE;
   assign host_interrupt = int_r;
   assign data_out = data_out_r;
   assign disk_wr_data = wr_data_r;
   assign step = step_r;
   assign direction_in = dir_r;
   assign write_gate = gate_r;
   assign precomp_en = pcomp_r && gate_r;
   assign format_active = op_r == dmcs_pkg::CMD_FORMAT && busy;
   assign raw_ecc = flag_l_r;
endmodule : dmcs_sequencer

// [core/dmcs_step_timer.sv]
// step interval timer: one pulse after the programmed interval
`timescale 1ns/1ps
module dmcs_step_timer
(
   // clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // control
   input wire logic start,
   input wire logic [23:0] interval,
   // result
   output logic expired
);
   logic [23:0] cnt_r;
   logic run_r;

   // ----------------------------------------------------------------
   // countdown
   // ----------------------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (!resetn)
      begin
         cnt_r <= 24'h00_0000;
         run_r <= 1'b0;
      end
      else if (start)
      begin
         cnt_r <= interval;
         run_r <= 1'b1;
      end
      else if (run_r && cnt_r == 24'h00_0000)
         run_r <= 1'b0;
      else if (run_r)
         cnt_r <= cnt_r - 24'h00_0001;
   end

   assign expired = run_r && cnt_r == 24'h00_0000;
endmodule : dmcs_step_timer

// [dv/dmcs_drive_model.sv]
// drive side model: head position, seek settling, sector stream
`timescale 1ns/1ps
module dmcs_drive_model
(
   // clock
   input wire logic mclk,
   // head control
   input wire logic step,
   input wire logic direction_in,
   input wire logic write_gate,
   // status and data
   output logic track0,
   output logic seek_complete,
   output logic id_found,
   output logic [7:0] disk_rd_data,
   output logic disk_rd_valid,
   output logic disk_wr_take
);
   int cyl_r = 2;
   int settle_r = 0;
   logic [11:0] tick_r = 12'h000;
   always @(posedge mclk)
   begin
      tick_r <= (tick_r == 12'hBB7) ? 12'h000 : tick_r + 12'h001;
      if (step)
      begin
         cyl_r <= direction_in ? cyl_r + 1 : (cyl_r > 0 ? cyl_r - 1 : 0);
         settle_r <= 40;
      end
      else if (settle_r > 0)
         settle_r <= settle_r - 1;
   end
   assign track0 = (cyl_r == 0);
   // settling drops after each step
   assign seek_complete = (settle_r == 0);
   assign id_found = (tick_r == 12'h000);
   assign disk_rd_valid = (tick_r[1:0] == 2'b01) && (tick_r < 12'h811);
   // between strobes the data lines toggle
   assign disk_rd_data = disk_rd_valid ? tick_r[9:2] : ~tick_r[7:0];
   assign disk_wr_take = write_gate && (tick_r[1:0] == 2'b11);
endmodule : dmcs_drive_model

// [dv/dmcs_seq_asserts.sv]
// concurrent checks on the sequencer ports
`timescale 1ns/1ps
module dmcs_seq_asserts
(
   // clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // watched ports
   input wire logic cmd_write,
   input wire logic floppy_sel,
   input wire logic [9:0] target_cyl,
   input wire logic [9:0] precomp_cyl,
   input wire logic write_fault,
   input wire logic busy,
   input wire logic step,
   input wire logic write_gate,
   input wire logic precomp_en,
   input wire logic transfer_request,
   input wire logic host_interrupt
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!resetn);
   sequence s_accept;
      cmd_write && !busy;
   endsequence
   sequence s_quiet8;
      !step [*8];
   endsequence
   a_busy_on_cmd: assert property (s_accept |=> busy)
      else $error("busy missing after command");
   a_irq_clear: assert property (s_accept |=> !host_interrupt)
      else $error("interrupt not cleared by command");
   a_fault_no_step: assert property (s_accept ##0 (write_fault && !floppy_sel) |=> s_quiet8)
      else $error("step issued with drive fault");
   a_step_gap: assert property (step |=> s_quiet8)
      else $error("steps too close");
   a_idle_quiet: assert property (!busy |-> !step && !write_gate && !transfer_request)
      else $error("activity while idle");
   a_gate_busy: assert property (write_gate |-> busy && !transfer_request && !step)
      else $error("write gate outside disk phase");
   a_done_irq: assert property ($fell(busy) |-> host_interrupt)
      else $error("no interrupt at completion");
   a_precomp_match: assert property (write_gate ##1 write_gate |->
      precomp_en == (!floppy_sel && target_cyl >= precomp_cyl))
      else $error("precompensation wrong");
endmodule : dmcs_seq_asserts

bind dmcs_sequencer dmcs_seq_asserts u_dmcs_seq_asserts (.mclk, .resetn, .cmd_write,
   .floppy_sel, .target_cyl, .precomp_cyl, .write_fault, .busy, .step, .write_gate,
   .precomp_en, .transfer_request, .host_interrupt);

// [dv/tb.sv]
// self-checking testbench of the sequencer
`timescale 1ns/1ps
module tb;
   logic mclk = 0, resetn = 0, cmd_write = 0, data_rd = 0, data_wr = 0, write_fault = 0;
   logic [7:0] cmd_byte = 8'h00, data_in = 8'h00, data_out, disk_rd_data, wr_data;
   logic [9:0] target_cyl = 10'h000, precomp_cyl = 10'h000;
   logic transfer_request, host_interrupt, busy, step, direction_in, write_gate, precomp_en;
   logic track0, seek_complete, id_found, disk_rd_valid, disk_wr_take, format_active, raw_ecc;
   logic floppy_sel = 0;
   logic [7:0] sect_cnt = 8'h01, sect_cnt_rb, sect_num_rb;
   logic gate_seen = 0, pre_seen = 0;
   int error_cnt = 0, num_checks = 0, steps = 0, gap = 0, min_gap = 0;
   logic [7:0] wr_q[$];
   initial
   begin
      forever #2 mclk = ~mclk;
   end
   dmcs_sequencer u_dmcs_sequencer (.mclk, .resetn, .cmd_write, .cmd_byte,
      .sector_count(sect_cnt), .sector_number(8'h01), .target_cyl, .precomp_cyl,
      .floppy_sel, .data_rd, .data_wr, .data_in, .data_out, .transfer_request,
      .host_interrupt, .busy, .sector_number_rb(sect_num_rb), .sector_count_rb(sect_cnt_rb),
      .step, .direction_in,
      .write_gate, .precomp_en, .track0, .seek_complete, .drive_ready(1'b1), .write_fault,
      .id_found, .disk_rd_data, .disk_rd_valid, .disk_wr_data(wr_data), .disk_wr_take,
      .format_active, .raw_ecc);
   dmcs_drive_model u_dmcs_drive_model (.mclk, .step, .direction_in, .write_gate, .track0,
      .seek_complete, .id_found, .disk_rd_data, .disk_rd_valid, .disk_wr_take);
   always @(posedge mclk)
   begin
      gap <= gap + 1;
      if (step)
      begin
         steps <= steps + 1;
         gap <= 0;
         if (steps > 0 && gap < min_gap)
            min_gap <= gap;
      end
      if (write_gate)
         gate_seen <= 1;
      if (precomp_en)
         pre_seen <= 1;
      if (disk_wr_take && write_gate)
         wr_q.push_back(wr_data);
   end
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic close_out;
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : close_out
   // cylinder loaded with the command byte last
   task automatic issue(input logic [7:0] cmd, input logic [9:0] cyl);
      @(negedge mclk);
      target_cyl = cyl;
      cmd_byte = cmd;
      cmd_write = 1;
      @(negedge mclk);
      cmd_write = 0;
   endtask : issue
   // wait for idle, or for a transfer request
   task automatic wait_on(input int lim, input logic want_drq);
      int n = 0;
      @(negedge mclk);
      while ((want_drq ? transfer_request !== 1'b1 : busy !== 1'b0) && n < lim)
      begin
         @(negedge mclk);
         n++;
      end
      if (n >= lim)
         chk("wait bound", 16'h0000, 16'h0001);
   endtask : wait_on
   // host data bytes, one write every other cycle
   task automatic fill(input int n, input logic [7:0] key);
      for (int k = 0; k < n; k++)
      begin
         @(negedge mclk);
         data_in = k[7:0] ^ key;
         data_wr = 1;
         @(negedge mclk);
         data_wr = 0;
      end
   endtask : fill
   task automatic t_restore;
      steps = 0;
      issue(8'h1F, 10'h000);
      wait_on(4000, 0);
      chk("restore steps", 16'h0002, 16'(steps));
      chk("track0", 16'h0001, 16'(track0));
      $display("test restore done");
   endtask : t_restore
   task automatic t_seek;
      steps = 0;
      min_gap = 1000000;
      issue(8'h70, 10'h002);
      issue(8'h7F, 10'h005);
      wait_on(30000, 0);
      chk("seek steps", 16'h0002, 16'(steps));
      chk("step gap", 16'h0001, 16'(min_gap >= dmcs_pkg::ZERO_CYC - 1));
      chk("seek irq", 16'h0001, 16'(host_interrupt));
      $display("test seek done");
   endtask : t_seek
   task automatic t_fault;
      write_fault = 1;
      steps = 0;
      issue(8'h70, 10'h005);
      wait_on(500, 0);
      chk("fault steps", 16'h0000, 16'(steps));
      chk("fault irq", 16'h0001, 16'(host_interrupt));
      issue(8'h22, 10'h005);
      wait_on(500, 0);
      chk("fault read irq", 16'h0001, 16'(host_interrupt));
      chk("raw ecc", 16'h0001, 16'(raw_ecc));
      write_fault = 0;
      $display("test fault done");
   endtask : t_fault
   task automatic t_read;
      steps = 0;
      issue(8'h20, 10'h001);
      wait_on(20000, 1);
      chk("read seek steps", 16'h0001, 16'(steps));
      chk("irq before data", 16'h0001, 16'(host_interrupt));
      for (int k = 0; k < dmcs_pkg::SECT_BYTES; k++)
      begin
         @(negedge mclk);
         chk("read byte", 16'(k[7:0]), 16'(data_out));
         data_rd = 1;
         @(negedge mclk);
         data_rd = 0;
      end
      wait_on(100, 0);
      chk("read request off", 16'h0000, 16'(transfer_request));
      $display("test read done");
   endtask : t_read
   task automatic t_write;
      wr_q.delete();
      issue(8'h30, 10'h001);
      wait_on(100, 1);
      chk("gate during fill", 16'h0000, 16'(write_gate));
      fill(dmcs_pkg::SECT_BYTES, 8'hA5);
      wait_on(20000, 0);
      chk("disk bytes", 16'h0200, 16'(wr_q.size()));
      for (int k = 0; k < dmcs_pkg::SECT_BYTES; k++)
         chk("disk byte", 16'(k[7:0] ^ 8'hA5), 16'(wr_q[k]));
      chk("gate seen", 16'h0001, 16'(gate_seen));
      chk("precomp seen", 16'h0001, 16'(pre_seen));
      $display("test write done");
   endtask : t_write
   task automatic t_format;
      wr_q.delete();
      pre_seen = 0;
      steps = 0;
      sect_cnt = 8'h03;
      precomp_cyl = 10'h003;
      issue(8'h50, 10'h002);
      wait_on(100, 1);
      chk("format active", 16'h0001, 16'(format_active));
      fill(6, 8'h5A);
      wait_on(20000, 0);
      chk("format steps", 16'h0001, 16'(steps));
      chk("format bytes", 16'h0006, 16'(wr_q.size()));
      for (int k = 0; k < 6; k++)
         chk("format byte", 16'(k[7:0] ^ 8'h5A), 16'(wr_q[k]));
      chk("format precomp", 16'h0000, 16'(pre_seen));
      chk("count readback", 16'h0003, 16'(sect_cnt_rb));
      chk("number readback", 16'h0001, 16'(sect_num_rb));
      sect_cnt = 8'h01;
      $display("test format done");
   endtask : t_format
   task automatic t_floppy;
      floppy_sel = 1;
      write_fault = 1;
      steps = 0;
      issue(8'h70, 10'h003);
      wait_on(20000, 0);
      chk("floppy steps", 16'h0001, 16'(steps));
      floppy_sel = 0;
      write_fault = 0;
      $display("test floppy done");
   endtask : t_floppy
   initial
   begin
      repeat (60000) @(posedge mclk);
      error_cnt++;
      close_out();
   end
   initial
   begin
      repeat (12) @(negedge mclk);
      resetn = 1;
      t_restore();
      t_seek();
      t_fault();
      t_read();
      t_write();
      t_format();
      t_floppy();
      close_out();
   end
endmodule : tb

// [inc/dmcs_pkg.sv]
// constants and types of the disk macro command sequencer
package dmcs_pkg;
   // ----------------------------------------------------------------
   // command byte layout
   // ----------------------------------------------------------------
   localparam logic [3:0] CMD_RESTORE = 4'h1;
   localparam logic [3:0] CMD_SEEK = 4'h7;
   localparam logic [3:0] CMD_READ = 4'h2;
   localparam logic [3:0] CMD_WRITE = 4'h3;
   localparam logic [3:0] CMD_FORMAT = 4'h5;
   localparam int CMD_OP_HI = 7;
   localparam int CMD_OP_LO = 4;
   localparam int RATE_HI = 3;
   localparam int RATE_LO = 0;
   localparam int FLAG_D = 3;
   localparam int FLAG_M = 2;
   localparam int FLAG_L = 1;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 250;
   localparam int RATE_UNIT_US = 500;
   localparam int RATE_ZERO_US_X10 = 200;
   localparam int UNIT_CYC = (RATE_UNIT_US * CLK_MHZ) / 1;
   localparam int ZERO_CYC = (RATE_ZERO_US_X10 * CLK_MHZ + 9) / 10;
   localparam int FLOPPY_RATE_MS = 8;
   localparam int FLOPPY_RATE_CYC = FLOPPY_RATE_MS * 1000 * CLK_MHZ;
   localparam int STEP_PULSE_NS = 8;
   localparam int STEP_PULSE_CYC = (STEP_PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam int CNT_W = 24;
   localparam logic [3:0] RATE_RESET = 4'h0;
   localparam logic [3:0] FLOPPY_RATE_CODE = 4'h0;
   // ----------------------------------------------------------------
   // buffer
   // ----------------------------------------------------------------
   localparam int SECT_BYTES = 512;
   localparam int ECC_BYTES = 4;
   localparam int BUF_DEPTH = SECT_BYTES + ECC_BYTES;
   localparam int PTR_W = 10;
   localparam int FMT_ENTRY_BYTES = 2;
   // ----------------------------------------------------------------
   // sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0000,
      ST_CHECK = 4'b0001,
      ST_STEP = 4'b0011,
      ST_WAIT = 4'b0010,
      ST_HOSTIN = 4'b0110,
      ST_FIND = 4'b0111,
      ST_DISK = 4'b0101,
      ST_HOSTOUT = 4'b0100,
      ST_NEXT = 4'b1100,
      ST_DONE = 4'b1101
   } dmcs_state_e;
endpackage : dmcs_pkg
